//--- dv/fcirq_chk_properties.sv
/* Assertions on the ports of the flash interrupt logic.
   Assumes a bind to fcirq_top and one clock domain. */
`timescale 1ns/1ps
module fcirq_chk #(parameter NUM_BLK = 32, parameter BLK_W = 5) (
  input wire               ref_clk,
  input wire               rst,
  input wire [11:0]        reg_addr,
  input wire [31:0]        reg_wdata,
  input wire               reg_wr,
  input wire               reg_rd,
  input wire [31:0]        reg_rdata_r,
  input wire               write_done,
  input wire               page_erase_done,
  input wire               mass_erase_done,
  input wire               read_attempt,
  input wire               program_attempt,
  input wire [BLK_W-1:0]   access_block,
  input wire [NUM_BLK-1:0] flash_read_protect_enable,
  input wire [NUM_BLK-1:0] flash_program_protect_enable,
  input wire               flash_irq_r
);
  reg  [1:0] m_r;
  wire done = write_done | page_erase_done | mass_erase_done;
  wire bad  = read_attempt & ~flash_read_protect_enable[access_block]
            | program_attempt & ~flash_program_protect_enable[access_block];
  wire ev   = done | read_attempt | program_attempt;
  wire cwr  = reg_wr && reg_addr == 12'h014;
  // The mask is not a port, so a mirror of it is kept here.
  always @(posedge ref_clk or posedge rst)
    if (rst) m_r <= 2'h0;
    else if (reg_wr && reg_addr == 12'h010) m_r <= reg_wdata[1:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // An attempt reaches its flag two edges late, so two quiet cycles precede a clean clear, which is quiet too.
  sequence s_quiet; !ev [*2]; endsequence
  sequence s_clr; s_quiet ##1 (!ev && cwr && reg_wdata[1:0] == 2'h3); endsequence
  property p_prog; done |=> !m_r[1] || flash_irq_r; endproperty
  a_prog: assert property (p_prog) else $error("prog irq missing");
  property p_acc; bad |=> ##1 (!m_r[0] || flash_irq_r); endproperty
  a_acc: assert property (p_acc) else $error("access irq missing");
  property p_gate; flash_irq_r |-> m_r != 2'h0; endproperty
  a_gate: assert property (p_gate) else $error("irq while masked");
  property p_mis; reg_rd && reg_addr == 12'h014 |=> (reg_rdata_r[1:0] != 2'h0) == $past(flash_irq_r); endproperty
  a_mis: assert property (p_mis) else $error("status disagrees with irq");
  property p_clr; s_clr |=> !flash_irq_r; endproperty
  a_clr: assert property (p_clr) else $error("clear failed");
  property p_w0; cwr && reg_wdata[1:0] == 2'h0 && flash_irq_r |=> flash_irq_r; endproperty
  a_w0: assert property (p_w0) else $error("zero write cleared");
  property p_moff; reg_wr && reg_addr == 12'h010 && reg_wdata[1:0] == 2'h0 |=> !flash_irq_r; endproperty
  a_moff: assert property (p_moff) else $error("irq after mask off");
  property p_rsv; reg_rdata_r[31:2] == 30'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule // fcirq_chk
bind fcirq_top fcirq_chk #(.NUM_BLK(NUM_BLK), .BLK_W(BLK_W)) u_fcirq_chk (.ref_clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata_r, .write_done, .page_erase_done, .mass_erase_done, .read_attempt, .program_attempt,
  .access_block, .flash_read_protect_enable, .flash_program_protect_enable, .flash_irq_r);

//--- dv/fcirq_intc_model.sv
/* Processor interrupt controller model that counts flash requests.
   Assumes the request is a level on ref_clk. */
`timescale 1ns/1ps
module fcirq_intc_model (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       irq,
  output reg  [7:0] taken_r
);
  reg seen_r;
  // A held level is one interrupt, not one per cycle.
  always @(posedge ref_clk or posedge rst)
    if (rst) {seen_r, taken_r} <= 9'h0;
    else {seen_r, taken_r} <= {irq, taken_r + {7'h0, irq & ~seen_r}};
endmodule // fcirq_intc_model

//--- dv/testbench.sv
/* Self-checking bench for the flash interrupt logic.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module testbench;
  reg         ref_clk = 1'b0;
  reg         rst = 1'b1;
  reg  [11:0] reg_addr = 12'h0;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [4:0]  evt = 5'h0;
  reg  [4:0]  blk = 5'h0;
  reg  [31:0] rd_en = 32'h0;
  reg  [31:0] pg_en = 32'h0;
  reg  [31:0] rnd = 32'h0;
  wire [31:0] reg_rdata_r;
  wire        flash_irq_r;
  wire [7:0]  taken;
  reg         rd_q = 1'b0;
  reg  [31:0] exp_q[$];
  integer     err_total = 0, total_checks = 0, cyc = 0, edges = 4, i;
  always #20 ref_clk = ~ref_clk;
  fcirq_top u_fcirq_top (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .write_done(evt[4]),
    .page_erase_done(evt[3]), .mass_erase_done(evt[2]), .read_attempt(evt[1]), .program_attempt(evt[0]),
    .access_block(blk), .flash_read_protect_enable(rd_en), .flash_program_protect_enable(pg_en), .flash_irq_r);
  fcirq_intc_model u_fcirq_intc_model (.ref_clk, .rst, .irq(flash_irq_r), .taken_r(taken));
  task check(input string nm, input [31:0] e, input [31:0] s);
    total_checks = total_checks + 1;
    if (e !== s) begin
      err_total = err_total + 1;
      $display("ERROR %s exp %h got %h", nm, e, s);
    end
  endtask
  task finish_test;
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    rd_q <= reg_rd;
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      finish_test;
    end
  end
  always @(negedge ref_clk) if (rd_q) check("rdata", exp_q.pop_front(), reg_rdata_r);
  task bus(input w, input [11:0] a, input [31:0] d);
    @(posedge ref_clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
    if (!w) exp_q.push_back(d);
    @(posedge ref_clk);
    {reg_wr, reg_rd} <= 2'b00;
  endtask
  task pulse(input [4:0] v, input e);
    @(posedge ref_clk);
    evt <= v;
    @(posedge ref_clk);
    evt <= 5'h0;
    #1 check("irq", {31'h0, e}, {31'h0, flash_irq_r});
  endtask
  initial begin
    i = $urandom(32'h4f64c8ff);
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    bus(0, 12'h010, 32'h0);
    pulse(5'h10, 1'b0);
    bus(0, 12'h00c, 32'h2);
    bus(0, 12'h014, 32'h0);
    bus(1, 12'h010, 32'h3);
    bus(0, 12'h014, 32'h2);
    bus(1, 12'h014, 32'h0);
    bus(0, 12'h014, 32'h2);
    bus(1, 12'h014, 32'h2);
    bus(0, 12'h00c, 32'h0);
    for (i = 2; i < 4; i = i + 1) begin
      pulse(5'h1 << i, 1'b1);
      bus(1, 12'h014, 32'h2);
    end
    for (i = 0; i < 10; i = i + 1) begin
      rnd   = $urandom;
      blk   <= rnd[4:0];
      rd_en <= i ? $urandom : 32'h0;
      pg_en <= $urandom;
      pulse(i[0] ? 5'h1 : 5'h2, 1'b0);
      bus(0, 12'h014, {31'h0, i[0] ? !pg_en[blk] : !rd_en[blk]});
      edges = edges + (i[0] ? !pg_en[blk] : !rd_en[blk]);
      bus(1, 12'h014, 32'h3);
      bus(0, 12'h00c, 32'h0);
    end
    bus(1, 12'h010, 32'h1);
    pulse(5'h10, 1'b0);
    bus(1, 12'h010, 32'h2);
    bus(0, 12'h014, 32'h2);
    bus(1, 12'h010, 32'h0);
    bus(0, 12'h00c, 32'h2);
    bus(0, 12'h020, 32'h0);
    check("taken", edges, {24'h0, taken});
    repeat (2) @(posedge ref_clk);
    finish_test;
  end
endmodule // testbench

//--- hdl/fcirq_flag.v
/*
  Holds one sticky event flag that hardware sets and software clears.
  Assumes set and clear are single-cycle terms from the ref_clk domain.
*/
`timescale 1ns/1ps
`include "fcirq_map.vh"

module fcirq_flag (
  input  wire ref_clk,
  input  wire rst,
  input  wire set,
  input  wire clr,
  output reg  flag_r
);

  // A clear that meets a new event in the same cycle must not lose the event.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag_r <= `FCIRQ_FLAG_RST;
    end else if (set) begin
      flag_r <= 1'b1;
    end else if (clr) begin
      flag_r <= 1'b0;
    end
  end

endmodule // fcirq_flag

//--- hdl/fcirq_map.vh
/*
  Holds the register offsets, field positions and reset values of the flash
  controller interrupt logic.
  Assumes it is included by bare name from files under hdl/.
*/
`ifndef FCIRQ_MAP_VH
`define FCIRQ_MAP_VH

`define FCIRQ_ADDR_W        12
`define FCIRQ_DATA_W        32
`define FCIRQ_RAW_OFS       12'h00c
`define FCIRQ_MASK_OFS      12'h010
`define FCIRQ_MIS_OFS       12'h014
`define FCIRQ_ACC_BIT       0
`define FCIRQ_PROG_BIT      1
`define FCIRQ_NUM_SRC       2
`define FCIRQ_MASK_RST      2'h0
`define FCIRQ_FLAG_RST      1'h0
`define FCIRQ_RDATA_RST     32'h0000_0000

`endif

//--- hdl/fcirq_prot_chk.v
/*
  Holds the check of a flash read or program attempt against the per-block
  read and program enable bits, and reports a forbidden attempt.
  Assumes attempts, block index and enable vectors come from ref_clk logic.
*/
`timescale 1ns/1ps

module fcirq_prot_chk #(
  parameter NUM_BLK = 32,
  parameter BLK_W   = 5
) (
  input  wire               ref_clk,
  input  wire               rst,
  input  wire               read_attempt,
  input  wire               program_attempt,
  input  wire [BLK_W-1:0]   access_block,
  input  wire [NUM_BLK-1:0] flash_read_protect_enable,
  input  wire [NUM_BLK-1:0] flash_program_protect_enable,
  output reg                violation_r
);

  wire rd_ok;
  wire pg_ok;

  // An index past the last block has no enable bit and counts as forbidden.
  assign rd_ok = (access_block < NUM_BLK) && flash_read_protect_enable[access_block];
  assign pg_ok = (access_block < NUM_BLK) && flash_program_protect_enable[access_block];

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      violation_r <= 1'b0;
    end else begin
      violation_r <= (read_attempt && !rd_ok) || (program_attempt && !pg_ok); // [R10]
    end
  end

endmodule // fcirq_prot_chk

//--- hdl/fcirq_top.v
/*
  Holds the interrupt masking and reporting logic of the flash controller:
  raw event flags, the mask register, the masked status and clear register,
  and the single interrupt request to the processor interrupt controller.
  Assumes all inputs come from logic on ref_clk, and a register port master
  that issues one-cycle strobes and takes read data in the following cycle.
*/
// How it works
// R1 - With the program-done mask bit set, a raw program-done flag raises the interrupt request.
// R2 - With the bad-access mask bit set, a raw bad-access flag raises the interrupt request.
// R3 - With a mask bit clear, its raw flag is still recorded but never reaches the request.
// R4 - Masked status bit 1 reads one only when a programming cycle completed and its mask is set.
// R5 - Writing one to masked status bit 1 clears it and the raw program-done flag; zero does nothing. The code clears only with mask bit 1 set.
// R6 - Masked status bit 0 reads one only when a bad access was tried and its mask is set.
// R7 - Writing one to masked status bit 0 clears it and the raw bad-access flag; zero does nothing. The code clears only with mask bit 0 set.
// R8 - Bits 31 to 2 of the mask and masked status registers are read-only and software leaves them alone.
// R9 - The raw program-done flag is set when a word write, page erase or mass erase cycle finishes.
// R10 - The raw bad-access flag is set by a read or program attempt that the protection enables forbid.
// R11 - The interrupt request is high while either masked status bit is one and low once both are clear.
`timescale 1ns/1ps
`include "fcirq_map.vh"

module fcirq_top #(
  parameter NUM_BLK = 32,
  parameter BLK_W   = 5
) (
  input  wire                     ref_clk,
  input  wire                     rst,
  input  wire [`FCIRQ_ADDR_W-1:0] reg_addr,
  input  wire [`FCIRQ_DATA_W-1:0] reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [`FCIRQ_DATA_W-1:0] reg_rdata_r,
  input  wire                     write_done,
  input  wire                     page_erase_done,
  input  wire                     mass_erase_done,
  input  wire                     read_attempt,
  input  wire                     program_attempt,
  input  wire [BLK_W-1:0]         access_block,
  input  wire [NUM_BLK-1:0]       flash_read_protect_enable,
  input  wire [NUM_BLK-1:0]       flash_program_protect_enable,
  output reg                      flash_irq_r
);

  reg  [`FCIRQ_NUM_SRC-1:0] flash_irq_mask_r;
  reg  [`FCIRQ_NUM_SRC-1:0] flash_irq_mask_nxt;
  wire [`FCIRQ_NUM_SRC-1:0] flash_raw_irq_status;
  wire [`FCIRQ_NUM_SRC-1:0] flash_masked_irq_status;
  wire [`FCIRQ_NUM_SRC-1:0] raw_set;
  wire [`FCIRQ_NUM_SRC-1:0] raw_clr;
  wire [`FCIRQ_NUM_SRC-1:0] raw_nxt;
  wire                      bad_access_hit;
  reg  [`FCIRQ_DATA_W-1:0]  rdata_nxt;

  // Widens a source vector to a bus word; the bits above read as zero.
  function [`FCIRQ_DATA_W-1:0] fcirq_word;
    input [`FCIRQ_NUM_SRC-1:0] bits;
    begin
      fcirq_word = {{(`FCIRQ_DATA_W-`FCIRQ_NUM_SRC){1'b0}}, bits};
    end
  endfunction

  fcirq_prot_chk #(
    .NUM_BLK (NUM_BLK),
    .BLK_W   (BLK_W)
  ) u_prot_chk (
    .ref_clk                      (ref_clk),
    .rst                          (rst),
    .read_attempt                 (read_attempt),
    .program_attempt              (program_attempt),
    .access_block                 (access_block),
    .flash_read_protect_enable    (flash_read_protect_enable),
    .flash_program_protect_enable (flash_program_protect_enable),
    .violation_r                  (bad_access_hit)
  );

  assign raw_set[`FCIRQ_PROG_BIT] = write_done || page_erase_done || mass_erase_done; // [R9]
  assign raw_set[`FCIRQ_ACC_BIT]  = bad_access_hit;                                  // [R10]

  // A write of one clears only a bit that currently shows as masked status,
  // so a masked-off flag cannot be cleared through this register.
  assign raw_clr = (reg_wr && reg_addr == `FCIRQ_MIS_OFS) ?
                   (reg_wdata[`FCIRQ_NUM_SRC-1:0] & flash_masked_irq_status) :
                   {`FCIRQ_NUM_SRC{1'b0}}; // [R5] [R7]

  genvar gi;
  generate
    for (gi = 0; gi < `FCIRQ_NUM_SRC; gi = gi + 1) begin : g_src
      fcirq_flag u_flag (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set     (raw_set[gi]),
        .clr     (raw_clr[gi]),
        .flag_r  (flash_raw_irq_status[gi])
      ); // [R3] [R5] [R7]
      assign raw_nxt[gi] = raw_set[gi] || (flash_raw_irq_status[gi] && !raw_clr[gi]);
    end
  endgenerate

  assign flash_masked_irq_status = flash_raw_irq_status & flash_irq_mask_r; // [R4] [R6]

  always @* begin
    flash_irq_mask_nxt = flash_irq_mask_r;
    if (reg_wr && reg_addr == `FCIRQ_MASK_OFS) begin
      flash_irq_mask_nxt = reg_wdata[`FCIRQ_NUM_SRC-1:0]; // [R8]
    end
  end

  always @* begin
    rdata_nxt = `FCIRQ_RDATA_RST;
    if (reg_rd) begin
      case (reg_addr)
        `FCIRQ_RAW_OFS:  rdata_nxt = fcirq_word(flash_raw_irq_status);
        `FCIRQ_MASK_OFS: rdata_nxt = fcirq_word(flash_irq_mask_r);     // [R8]
        `FCIRQ_MIS_OFS:  rdata_nxt = fcirq_word(flash_masked_irq_status); // [R4] [R6] [R8]
        default:         rdata_nxt = `FCIRQ_RDATA_RST;
      endcase
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flash_irq_mask_r <= `FCIRQ_MASK_RST;
      reg_rdata_r      <= `FCIRQ_RDATA_RST;
      flash_irq_r      <= 1'b0;
    end else begin
      flash_irq_mask_r <= flash_irq_mask_nxt;
      reg_rdata_r      <= rdata_nxt;
      // The request follows the flags and mask in the same cycle they change.
      flash_irq_r      <= |(raw_nxt & flash_irq_mask_nxt); // [R1] [R2] [R3] [R11]
    end
  end

endmodule // fcirq_top
